/* File: rtl/mtsc_codec.sv */
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module mtsc_codec
    import mtsc_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_b,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [7:0]        o_rdata,
    output logic                   o_ready,
    output logic                   o_error
);
    logic [7:0]  ctrl_reg;
    logic [7:0]  data_low_byte_reg;
    logic [7:0]  data_mid_byte_reg;
    logic [7:0]  data_high_byte_reg;
    logic [7:0]  rdata_reg;
    logic        go_reg;
    logic        go_enc_reg;

    wire         wr_ctrl = i_wr && (i_addr == ADDR_CTRL);
    wire         wr_low  = i_wr && (i_addr == ADDR_LOW);
    wire         wr_mid  = i_wr && (i_addr == ADDR_MID);
    wire         wr_high = i_wr && (i_addr == ADDR_HIGH);
    wire         mode    = ctrl_reg[BIT_MODE]; // RQ4
    wire         start_enc = wr_ctrl && i_wdata[BIT_ENC]; // RQ5
    wire         start_dec = wr_ctrl && i_wdata[BIT_DEC] && !i_wdata[BIT_ENC];
    wire [23:0]  data_bytes_all = {data_high_byte_reg, data_mid_byte_reg, data_low_byte_reg};

    // Per-nibble lookups; four lanes for the 24-bit symbol case
    logic [5:0] sym    [4];
    logic [3:0] sym_nib[4];
    logic [3:0] sym_ok;
    logic [7:0] man    [2];
    logic [3:0] man_nib[2];
    logic [1:0] man_ok;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            logic [7:0] man_o;
            logic [3:0] man_n;
            logic       man_k;
            mtsc_lut u_lut (
                .i_nib     (data_bytes_all[4*g+3:4*g]),
                .i_sym     (data_bytes_all[6*g+5:6*g]),
                .i_man     (data_bytes_all[8*(g%2)+7:8*(g%2)]),
                .o_sym     (sym[g]),
                .o_sym_nib (sym_nib[g]),
                .o_sym_ok  (sym_ok[g]),
                .o_man     (man_o),
                .o_man_nib (man_n),
                .o_man_ok  (man_k)
            );
            if (g < 2) begin : g_man
                assign man[g]     = man_o;
                assign man_nib[g] = man_n;
                assign man_ok[g]  = man_k;
            end
        end
    endgenerate

    // Manchester encode: high nibble to mid byte, low nibble to low byte
    wire [23:0] man_enc = {8'h00, man[1], man[0]}; // RQ6 RQ3 RQ1 RQ2
    wire        man_good = &man_ok;
    // Manchester decode output is a single low byte, or all ones on error
    wire [23:0] man_dec = man_good ? {16'h0000, man_nib[1], man_nib[0]}
                                   : {8'h00, MAN_BAD_OUT}; // RQ12 RQ13 RQ15
    // Symbol order keeps the top nibble in the top field
    wire [23:0] tos_enc = {sym[3], sym[2], sym[1], sym[0]}; // RQ17 RQ25 RQ16
    wire [23:0] tos_dec = {8'h00, sym_nib[3], sym_nib[2], sym_nib[1], sym_nib[0]}; // RQ19 RQ22
    wire        tos_good = &sym_ok;

    wire [23:0] result = go_enc_reg ? (mode ? tos_enc : man_enc)
                                    : (mode ? tos_dec : man_dec);
    wire        bad    = !go_enc_reg && (mode ? !tos_good : !man_good);

    // Control: start bits never stored, so they read back as zero
    logic [7:0] ctrl_next;
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = i_wdata & CTRL_RW_MASK;
            ctrl_next[BIT_ENC] = 1'b0; // RQ9
            ctrl_next[BIT_DEC] = 1'b0;
            // Flags: software may only clear them, a write of one keeps them
            ctrl_next[BIT_READY] = ctrl_reg[BIT_READY] & i_wdata[BIT_READY]; // RQ11 RQ24
            ctrl_next[BIT_ERROR] = ctrl_reg[BIT_ERROR] & i_wdata[BIT_ERROR];
        end
        if (go_reg) begin
            ctrl_next[BIT_READY] = 1'b1; // RQ10
            if (bad) begin
                ctrl_next[BIT_ERROR] = 1'b1; // RQ20 RQ26
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            ctrl_reg   <= CTRL_RST;
            go_reg     <= 1'b0;
            go_enc_reg <= 1'b0;
        end else begin
            ctrl_reg   <= ctrl_next;
            go_reg     <= start_enc || start_dec;
            go_enc_reg <= start_enc;
        end
    end

    // Data registers: result overwrites input one cycle after start
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            data_low_byte_reg  <= DATA_RST;
            data_mid_byte_reg  <= DATA_RST;
            data_high_byte_reg <= DATA_RST;
        end else if (go_reg) begin
            {data_high_byte_reg, data_mid_byte_reg, data_low_byte_reg} <= result; // RQ8
        end else begin
            if (wr_low) begin
                data_low_byte_reg <= i_wdata;
            end
            if (wr_mid) begin
                data_mid_byte_reg <= i_wdata;
            end
            if (wr_high) begin
                data_high_byte_reg <= i_wdata;
            end
        end
    end

    wire [7:0] rd_mux = (i_addr == ADDR_CTRL) ? ctrl_reg :
                        (i_addr == ADDR_LOW)  ? data_low_byte_reg :
                        (i_addr == ADDR_MID)  ? data_mid_byte_reg : data_high_byte_reg;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= i_rd ? rd_mux : 8'h00;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_ready = ctrl_reg[BIT_READY];
    assign o_error = ctrl_reg[BIT_ERROR];

    property p_ready_after_start;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (start_enc || start_dec) |=> ##0 1'b1 ##1 o_ready;
    endproperty
    a_ready_after_start: assert property (p_ready_after_start) // RQ10
        else $error("ready not set after start");

    property p_start_self_clear;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        wr_ctrl |=> !ctrl_reg[BIT_ENC] && !ctrl_reg[BIT_DEC];
    endproperty
    a_start_self_clear: assert property (p_start_self_clear) // RQ9
        else $error("start bit stuck");

    property p_ready_sticky;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_ready && !wr_ctrl) |=> o_ready;
    endproperty
    a_ready_sticky: assert property (p_ready_sticky) // RQ10
        else $error("ready cleared by hardware");

    property p_error_sticky;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_error && !wr_ctrl) |=> o_error;
    endproperty
    a_error_sticky: assert property (p_error_sticky) // RQ26
        else $error("error cleared by hardware");

    property p_man_enc_high_zero;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (start_enc && !i_wdata[BIT_MODE] && !wr_high) |=> ##1 (data_high_byte_reg == 8'h00);
    endproperty
    a_man_enc_high_zero: assert property (p_man_enc_high_zero) // RQ3
        else $error("manchester output touches high byte");

    property p_man_bad_ff;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (go_reg && !go_enc_reg && !mode && !man_good)
            |=> (data_low_byte_reg == 8'hFF) && o_error;
    endproperty
    a_man_bad_ff: assert property (p_man_bad_ff) // RQ13
        else $error("bad manchester not flagged");

    property p_man_enc_code;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (go_reg && go_enc_reg && !mode && data_low_byte_reg == 8'h0F)
            |=> (data_mid_byte_reg == 8'hAA) && (data_low_byte_reg == 8'h55);
    endproperty
    a_man_enc_code: assert property (p_man_enc_code) // RQ7
        else $error("manchester code wrong");

    property p_tos_bad_err;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (go_reg && !go_enc_reg && mode && !tos_good) |=> o_error;
    endproperty
    a_tos_bad_err: assert property (p_tos_bad_err) // RQ20
        else $error("bad symbol not flagged");

    property p_input_held;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (!go_reg && !i_wr) |=> $stable(data_bytes_all);
    endproperty
    a_input_held: assert property (p_input_held) // RQ8
        else $error("data changed without cause");

    property p_man_dec_upper_zero;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (go_reg && !go_enc_reg && !mode)
            |=> (data_high_byte_reg == 8'h00) && (data_mid_byte_reg == 8'h00);
    endproperty
    a_man_dec_upper_zero: assert property (p_man_dec_upper_zero) // RQ3
        else $error("manchester decode touches upper bytes");

    property p_tos_dec_high_zero;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (go_reg && !go_enc_reg && mode)
            |=> (data_high_byte_reg == 8'h00);
    endproperty
    a_tos_dec_high_zero: assert property (p_tos_dec_high_zero) // RQ2
        else $error("symbol decode touches high byte");

    property p_enc_no_error;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (go_reg && go_enc_reg && !o_error)
            |=> !o_error;
    endproperty
    a_enc_no_error: assert property (p_enc_no_error) // RQ20
        else $error("encode raised error");

    property p_ready_only_on_done;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (!o_ready && !go_reg)
            |=> !o_ready;
    endproperty
    a_ready_only_on_done: assert property (p_ready_only_on_done) // RQ10
        else $error("ready set without completion");

    property p_error_only_on_bad;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (!o_error && !(go_reg && bad))
            |=> !o_error;
    endproperty
    a_error_only_on_bad: assert property (p_error_only_on_bad) // RQ20
        else $error("error set without bad input");

    property p_start_reads_zero;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_rd && (i_addr == ADDR_CTRL))
            |=> !o_rdata[BIT_ENC] && !o_rdata[BIT_DEC];
    endproperty
    a_start_reads_zero: assert property (p_start_reads_zero) // RQ9
        else $error("start bit read back as one");

    property p_mode_follows_write;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        wr_ctrl
            |=> (mode == $past(i_wdata[BIT_MODE]));
    endproperty
    a_mode_follows_write: assert property (p_mode_follows_write) // RQ4
        else $error("code select not taken");

    property p_man_enc_zero_nib;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (go_reg && go_enc_reg && !mode && (data_low_byte_reg[7:4] == 4'h0))
            |=> (data_mid_byte_reg == 8'hAA);
    endproperty
    a_man_enc_zero_nib: assert property (p_man_enc_zero_nib) // RQ6
        else $error("manchester upper nibble code wrong");

    property p_man_enc_f_nib;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (go_reg && go_enc_reg && !mode && (data_low_byte_reg[3:0] == 4'hF))
            |=> (data_low_byte_reg == 8'h55);
    endproperty
    a_man_enc_f_nib: assert property (p_man_enc_f_nib) // RQ7
        else $error("manchester lower nibble code wrong");

    property p_man_dec_c;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (go_reg && !go_enc_reg && !mode && (data_mid_byte_reg == 8'h5A)
            && (data_low_byte_reg == 8'hAA)) |=> (data_low_byte_reg == 8'hC0);
    endproperty
    a_man_dec_c: assert property (p_man_dec_c) // RQ14
        else $error("manchester decode value wrong");

    property p_tos_enc_low;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (go_reg && go_enc_reg && mode && (data_low_byte_reg[3:0] == 4'h3))
            |=> (data_low_byte_reg[5:0] == 6'h0B);
    endproperty
    a_tos_enc_low: assert property (p_tos_enc_low) // RQ18
        else $error("symbol for lowest nibble wrong");

    property p_tos_enc_top;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (go_reg && go_enc_reg && mode && (data_mid_byte_reg[7:4] == 4'h0))
            |=> (data_high_byte_reg[7:2] == 6'h16);
    endproperty
    a_tos_enc_top: assert property (p_tos_enc_top) // RQ25
        else $error("top nibble not in top field");

    property p_tos_dec_low;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (go_reg && !go_enc_reg && mode && (data_low_byte_reg[5:0] == 6'h0B))
            |=> (data_low_byte_reg[3:0] == 4'h3);
    endproperty
    a_tos_dec_low: assert property (p_tos_dec_low) // RQ21
        else $error("lowest symbol decoded wrong");

    property p_tos_dec_top;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (go_reg && !go_enc_reg && mode && (data_high_byte_reg[7:2] == 6'h34))
            |=> (data_mid_byte_reg[7:4] == 4'hC);
    endproperty
    a_tos_dec_top: assert property (p_tos_dec_top) // RQ21
        else $error("top symbol decoded wrong");

    property p_write_clears_ready;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (wr_ctrl && !i_wdata[BIT_READY] && !go_reg)
            |=> !o_ready;
    endproperty
    a_write_clears_ready: assert property (p_write_clears_ready) // RQ11
        else $error("ready not cleared by write");

    property p_write_clears_error;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (wr_ctrl && !i_wdata[BIT_ERROR] && !go_reg)
            |=> !o_error;
    endproperty
    a_write_clears_error: assert property (p_write_clears_error) // RQ26
        else $error("error not cleared by write");

    c_man_enc: cover property (@(posedge i_ref_clk) go_reg && go_enc_reg && !mode);
    c_man_dec: cover property (@(posedge i_ref_clk) go_reg && !go_enc_reg && !mode);
    c_tos_enc: cover property (@(posedge i_ref_clk) go_reg && go_enc_reg && mode);
    c_tos_err: cover property (@(posedge i_ref_clk) go_reg && bad && mode);
    c_man_err: cover property (@(posedge i_ref_clk) go_reg && bad && !mode);
endmodule

/* File: rtl/mtsc_pkg.sv */
// Overview of operation
// RQ1: Input sizes: 1,2,2,3 bytes per operation
// RQ2: Output sizes: 2,1,3,2 bytes per operation
// RQ3: Data right-justified; Manchester ignores high byte
// RQ4: Code-select 0 Manchester, 1 three-of-six
// RQ5: Writing encode-start begins encode in selected code
// RQ6: Upper nibble to middle, lower to low
// RQ7: Manchester: bit 0 to 10, 1 to 01
// RQ8: Input readable until start; output replaces it
// RQ9: Encode and decode start bits self-clear
// RQ10: Hardware only sets ready; software clears it
// RQ11: One control write clears ready and starts
// RQ12: Manchester decode reads middle, low; sets ready
// RQ13: Invalid Manchester byte: error, output all ones
// RQ14: Manchester decode inverts the encode mapping
// RQ15: Manchester encode then decode returns input
// RQ16: Each nibble becomes six bits, 24 total
// RQ17: Three-of-six encode: two bytes in, three out
// RQ18: Fixed sixteen-entry nibble-to-symbol table used
// RQ19: Three-of-six decode reads three bytes, sets ready
// RQ20: Any invalid six-bit field sets error flag
// RQ21: Each valid symbol decodes to its nibble
// RQ22: Three-of-six round trip reproduces two bytes
// RQ23: Software starts with control values 10,11,20,21
// RQ24: Software clears ready and error each operation
// RQ25: Most significant nibble in most significant field
// RQ26: Error stays set until software clears it
package mtsc_pkg;
    localparam int          ADDR_W       = 2;
    localparam logic [1:0]  ADDR_CTRL    = 2'h0;
    localparam logic [1:0]  ADDR_LOW     = 2'h1;
    localparam logic [1:0]  ADDR_MID     = 2'h2;
    localparam logic [1:0]  ADDR_HIGH    = 2'h3;
    localparam int          BIT_READY    = 7;
    localparam int          BIT_ERROR    = 6;
    localparam int          BIT_ENC      = 5;
    localparam int          BIT_DEC      = 4;
    localparam int          BIT_DMA      = 2;
    localparam int          BIT_ENDIAN   = 1;
    localparam int          BIT_MODE     = 0;
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [7:0]  DATA_RST     = 8'h00;
    localparam logic [7:0]  CTRL_RW_MASK = 8'h27 | 8'h10;
    localparam logic [15:0] MAN_BAD_OUT  = 16'h00FF;
    localparam logic [3:0]  TOS_BAD_NIB  = 4'hF;
endpackage

/* File: rtl/mtsc_lut.sv */
`timescale 1ns/1ps
module mtsc_lut
    import mtsc_pkg::*;
(
    input  wire logic [3:0] i_nib,
    input  wire logic [5:0] i_sym,
    input  wire logic [7:0] i_man,
    output logic      [5:0] o_sym,
    output logic      [3:0] o_sym_nib,
    output logic            o_sym_ok,
    output logic      [7:0] o_man,
    output logic      [3:0] o_man_nib,
    output logic            o_man_ok
);
    logic [5:0] sym_tab [16];
    assign sym_tab = '{6'h16, 6'h0D, 6'h0E, 6'h0B, 6'h1C, 6'h19, 6'h1A, 6'h13,
                       6'h2C, 6'h25, 6'h26, 6'h23, 6'h34, 6'h31, 6'h32, 6'h29}; // RQ18
    assign o_sym = sym_tab[i_nib]; // RQ16

    logic [15:0] hit;
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_inv
            assign hit[g] = (sym_tab[g] == i_sym); // RQ21
        end
        for (g = 0; g < 4; g++) begin : g_man
            assign o_man[2*g+1] = ~i_nib[g]; // RQ7
            assign o_man[2*g]   = i_nib[g];
            assign o_man_nib[g] = i_man[2*g]; // RQ14
        end
    endgenerate

    always_comb begin
        o_sym_nib = TOS_BAD_NIB;
        for (int k = 0; k < 16; k++) begin
            if (hit[k]) begin
                o_sym_nib = 4'(k);
            end
        end
    end
    assign o_sym_ok = |hit; // RQ20
    assign o_man_ok = ((i_man[7] ^ i_man[6]) & (i_man[5] ^ i_man[4])
                     & (i_man[3] ^ i_man[2]) & (i_man[1] ^ i_man[0])); // RQ13
endmodule

/* File: test/mtsc_core_model.sv */
`timescale 1ns/1ps
module mtsc_core_model
    import mtsc_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic [7:0]        i_rdata,
    output logic      [ADDR_W-1:0] o_addr,
    output logic      [7:0]        o_wdata,
    output logic                   o_wr,
    output logic                   o_rd
);
    initial begin
        o_addr  = ADDR_CTRL;
        o_wdata = 8'h00;
        o_wr    = 1'h0;
        o_rd    = 1'h0;
    end
    // Every call lets an edge pass first, so strobes never re-rise in one step
    // Control values are whole bytes with ready and error written as the caller gives them, zero clearing them
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'h1;
        @(posedge i_ref_clk);
        o_wr    <= 1'h0;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_rd   <= 1'h1;
        @(posedge i_ref_clk);
        o_rd   <= 1'h0;
        #1 d = i_rdata;
    endtask
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import mtsc_pkg::*;
    localparam logic [5:0] TOS [16] = '{6'h16, 6'h0D, 6'h0E, 6'h0B, 6'h1C, 6'h19,
        6'h1A, 6'h13, 6'h2C, 6'h25, 6'h26, 6'h23, 6'h34, 6'h31, 6'h32, 6'h29};
    logic              ref_clk;
    logic              rst_b;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
    logic [7:0]        rdata;
    logic              ready;
    logic              error;
    int                mismatches;
    int                checked;
    logic [7:0]        b;
    logic [15:0]       v;
    logic [23:0]       t;

    mtsc_core_model core_u (.i_ref_clk(ref_clk), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    mtsc_codec dut_u (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_ready(ready), .o_error(error));

    always #2.5 ref_clk = ~ref_clk;

    function automatic logic [7:0] man(input logic [3:0] n);
        for (int i = 0; i < 4; i++) begin
            man[2*i +: 2] = n[i] ? 2'h1 : 2'h2;
        end
    endfunction
    function automatic logic [23:0] tos(input logic [15:0] x);
        tos = {TOS[x[15:12]], TOS[x[11:8]], TOS[x[7:4]], TOS[x[3:0]]};
    endfunction
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd3(output logic [23:0] x);
        core_u.rd(ADDR_HIGH, x[23:16]);
        core_u.rd(ADDR_MID, x[15:8]);
        core_u.rd(ADDR_LOW, x[7:0]);
    endtask
    task automatic run(input logic [7:0] op, input logic [23:0] exp, input logic err);
        logic [23:0] x;
        core_u.wr(ADDR_CTRL, op);
        #1;
        chk("ready at start", ready, op[7]);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("ready", ready, 24'h1);
        chk("error", error, err);
        rd3(x);
        chk("data", x, exp);
        core_u.rd(ADDR_CTRL, x[7:0]);
        chk("ctrl", x[7:0], {1'h1, err, 3'h0, op[2:0]});
    endtask
    task automatic close_out;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        ref_clk    = 1'h0;
        rst_b      = 1'h0;
        mismatches = 0;
        checked    = 0;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'h1;
        void'($urandom(32'h75BC1C13));
        rd3(t);
        chk("reset data", t, 24'h0);
        core_u.rd(ADDR_CTRL, b);
        chk("reset ctrl", b, CTRL_RST);
        // First eight passes sweep every nibble through both tables
        for (int k = 0; k < 12; k++) begin
            b = (k < 8) ? 8'h01 + 8'h22 * k[7:0] : 8'($urandom);
            v = (k < 4) ? 16'h0123 + 16'h4444 * k[15:0] : 16'($urandom);
            core_u.wr(ADDR_LOW, b);
            core_u.rd(ADDR_LOW, t[7:0]);
            chk("input kept", t[7:0], b);
            run(8'h20, {8'h00, man(b[7:4]), man(b[3:0])}, 1'h0);
            run(8'h10, {16'h0000, b}, 1'h0);
            core_u.wr(ADDR_MID, v[15:8]);
            core_u.wr(ADDR_LOW, v[7:0]);
            run(8'h21, tos(v), 1'h0);
            run(8'h11, {8'h00, v}, 1'h0);
        end
        core_u.wr(ADDR_LOW, 8'h0F);
        run(8'h20, {8'h00, 8'hAA, 8'h55}, 1'h0);
        // Both start bits with the spare control bits set: encode wins
        core_u.wr(ADDR_MID, 8'hA5);
        core_u.wr(ADDR_LOW, 8'h3C);
        run(8'h37, tos(16'hA53C), 1'h0);
        core_u.wr(ADDR_MID, 8'h00);
        core_u.wr(ADDR_LOW, 8'hAA);
        run(8'h10, {16'h0000, 8'hFF}, 1'h1);
        core_u.wr(ADDR_MID, 8'h5A);
        core_u.wr(ADDR_LOW, 8'hAA);
        run(8'hD0, {16'h0000, 8'hC0}, 1'h1);
        t = {6'h00, TOS[1], TOS[2], TOS[3]};
        core_u.wr(ADDR_HIGH, t[23:16]);
        core_u.wr(ADDR_MID, t[15:8]);
        core_u.wr(ADDR_LOW, t[7:0]);
        run(8'h11, {8'h00, 16'hF123}, 1'h1);
        close_out();
    end

    // Whole run needs about 770 cycles
    initial begin
        repeat (8000) @(posedge ref_clk);
        mismatches++;
        close_out();
    end
endmodule
